//--- dv/sleep_wakeup_battery_monitor_test.sv
`include "swm_regs.svh"
module sleep_wakeup_battery_monitor_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 20000;
  logic clock, nrst, reg_wr, reg_rd, monitor_enable, timer_enable, slow_crystal_select, duty_cycle_receive;
  logic supply_irq_enable, wakeup_irq_enable, sleep_request, irq_read, rx_preamble_ok, rx_sync_ok, rx_search_fail;
  logic rc_osc_pin, slow_crystal_pin, irq_out_low, xtal30_en, host_clk_run, rc_osc_en, supply_monitor;
  logic gpio0_crystal_mode, wakeup_gpio, rx_enable;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd;
  logic [4:0] supply_code;
  int num_errors, num_checks, cycles, n;

  swm_supervisor #(
    .MEAS_INTERVAL(50),
    .MEAS_ON(5)
  ) dut_u (
    .clock, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .monitor_enable, .timer_enable, .slow_crystal_select, .duty_cycle_receive,
    .supply_irq_enable, .wakeup_irq_enable, .sleep_request, .irq_read,
    .rc_osc_pin, .slow_crystal_pin, .supply_code, .rx_preamble_ok, .rx_sync_ok, .rx_search_fail,
    .irq_out_low, .xtal30_en, .host_clk_run, .rc_osc_en, .supply_monitor,
    .gpio0_crystal_mode, .wakeup_gpio, .rx_enable
  );
  swm_slow_osc_model osc_u (.rc_osc_en, .gpio0_crystal_mode, .rc_osc_pin, .slow_crystal_pin);

  // 25 MHz clock
  always #20 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////////
  // shared helpers
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      num_errors++;
  endtask
  task automatic check_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp)
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    if (got !== exp)
      num_errors++;
  endtask
  // wait for a level under a bound, k returns the cycles spent
  task automatic wait_on(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim)
    begin
      step();
      k++;
    end
  endtask
  task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    step();
    reg_wr = 1'b0;
    step();
  endtask
  task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    step();
    d = reg_rdata;
    reg_rd = 1'b0;
    step();
  endtask
  task automatic pulse_irq_read();
    irq_read = 1'b1;
    step();
    irq_read = 1'b0;
  endtask
  // each measurement powers the monitor for exactly the on time
  task automatic wait_meas(input int cnt);
    repeat (cnt)
    begin
      wait_on(supply_monitor, 1'b1, 100, n);
      wait_on(supply_monitor, 1'b0, 20, n);
      check_byte(8'(n), 8'h05);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    reg_read(`SWM_ADDR_EXP, rd);
    check_byte(rd, 8'h03);
    reg_read(`SWM_ADDR_MANT_HI, rd);
    check_byte(rd, 8'h00);
    reg_read(`SWM_ADDR_MANT_LO, rd);
    check_byte(rd, 8'h00);
    reg_read(`SWM_ADDR_DUTY, rd);
    check_byte(rd, 8'h00);
    reg_read(`SWM_ADDR_THR, rd);
    check_byte(rd, 8'h14);
    reg_write(`SWM_ADDR_LEVEL, 8'hff);
    reg_read(`SWM_ADDR_LEVEL, rd);
    check_byte(rd, 8'h00);
    reg_read(7'h30, rd);
    check_byte(rd, 8'h00);
  endtask
  task automatic t_battery();
    reg_write(`SWM_ADDR_THR, 8'h10);
    supply_code = 5'h0f;
    supply_irq_enable = 1'b1;
    monitor_enable = 1'b1;
    wait_meas(3);
    wait_on(irq_out_low, 1'b0, 4, n);
    check_bit(irq_out_low, 1'b1);
    supply_code = 5'h10;
    wait_meas(1);
    reg_read(`SWM_ADDR_LEVEL, rd);
    check_byte(rd, 8'h10);
    supply_code = 5'h0f;
    wait_meas(3);
    wait_on(irq_out_low, 1'b0, 4, n);
    check_bit(irq_out_low, 1'b1);
    wait_meas(1);
    wait_on(irq_out_low, 1'b0, 4, n);
    check_bit(irq_out_low, 1'b0);
    sleep_request = 1'b1;
    repeat (3) step();
    check_bit(host_clk_run, 1'b1);
    check_bit(rc_osc_en, 1'b1);
    pulse_irq_read();
    repeat (2) step();
    check_bit(irq_out_low, 1'b1);
    check_bit(host_clk_run, 1'b0);
    monitor_enable = 1'b0;
    wait_on(supply_monitor, 1'b1, 120, n);
    check_bit(supply_monitor, 1'b0);
    sleep_request = 1'b0;
    supply_irq_enable = 1'b0;
  endtask
  task automatic t_timer();
    reg_write(`SWM_ADDR_EXP, 8'h00);
    reg_write(`SWM_ADDR_MANT_LO, 8'h02);
    wakeup_irq_enable = 1'b1;
    timer_enable = 1'b1;
    step();
    sleep_request = 1'b1;
    wait_on(irq_out_low, 1'b0, 300, n);
    check_bit(irq_out_low, 1'b0);
    check_bit(xtal30_en, 1'b1);
    reg_read(`SWM_ADDR_CNT_HI, rd);
    check_byte(rd, 8'h00);
    reg_read(`SWM_ADDR_CNT_LO, rd);
    check_bit(rd < 8'h02, 1'b1);
    pulse_irq_read();
    wait_on(irq_out_low, 1'b0, 300, n);
    pulse_irq_read();
    wait_on(irq_out_low, 1'b0, 300, n);
    check_bit(n >= 77 && n <= 81, 1'b1);
  endtask
  task automatic t_gpio();
    pulse_irq_read();
    wakeup_irq_enable = 1'b0;
    wait_on(wakeup_gpio, 1'b1, 100, n);
    check_bit(wakeup_gpio, 1'b1);
    check_bit(irq_out_low, 1'b1);
    check_bit(xtal30_en, 1'b0);
    step();
    check_bit(wakeup_gpio, 1'b0);
  endtask
  task automatic t_duty();
    reg_write(`SWM_ADDR_DUTY, 8'h01);
    duty_cycle_receive = 1'b1;
    wait_on(rx_enable, 1'b1, 100, n);
    check_bit(rx_enable, 1'b1);
    rx_search_fail = 1'b1;
    step();
    rx_search_fail = 1'b0;
    check_bit(rx_enable, 1'b0);
    wait_on(rx_enable, 1'b1, 100, n);
    rx_preamble_ok = 1'b1;
    rx_sync_ok = 1'b1;
    step();
    rx_preamble_ok = 1'b0;
    rx_sync_ok = 1'b0;
    wait_on(rx_enable, 1'b0, 100, n);
    check_bit(n >= 28 && n <= 45, 1'b1);
    duty_cycle_receive = 1'b0;
  endtask
  task automatic t_crystal();
    slow_crystal_select = 1'b1;
    repeat (3) step();
    check_bit(gpio0_crystal_mode, 1'b1);
    check_bit(rc_osc_en, 1'b0);
    wait_on(wakeup_gpio, 1'b1, 200, n);
    check_bit(wakeup_gpio, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // verdict, hang guard and main sequence
  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      num_errors++;
      print_verdict();
    end
  end
  initial
  begin
    {clock, nrst, reg_wr, reg_rd, monitor_enable, timer_enable, slow_crystal_select} = '0;
    {duty_cycle_receive, supply_irq_enable, wakeup_irq_enable, sleep_request, irq_read} = '0;
    {rx_preamble_ok, rx_sync_ok, rx_search_fail} = '0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    supply_code = 5'h1f;
    cycles = 0;
    num_errors = 0;
    num_checks = 0;
    repeat (3) @(posedge clock);
    #1;
    nrst = 1'b1;
    t_regs();
    t_battery();
    t_timer();
    t_gpio();
    t_duty();
    t_crystal();
    print_verdict();
  end
endmodule // sleep_wakeup_battery_monitor_test

//--- dv/swm_slow_osc_model.sv
////////////////////////////////////////////////////////////////////////////////
// slow clock sources in front of the device: rc oscillator with a 400 ns period and crystal with a 414 ns period
module swm_slow_osc_model #(
  parameter int HALF_NS = 200
) (
  input wire logic rc_osc_en,
  input wire logic gpio0_crystal_mode,
  output logic rc_osc_pin,
  output logic slow_crystal_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // rc oscillator swings only while the device asks for it, else rests low
  initial
  begin
    rc_osc_pin = 1'b0;
    forever
    begin
      #(HALF_NS);
      rc_osc_pin = rc_osc_en ? ~rc_osc_pin : 1'b0;
    end
  end
  // crystal swings only once pin 0 is handed to it, at a slightly different rate
  initial
  begin
    slow_crystal_pin = 1'b0;
    forever
    begin
      #(HALF_NS + 7);
      slow_crystal_pin = gpio0_crystal_mode ? ~slow_crystal_pin : 1'b0;
    end
  end
endmodule // swm_slow_osc_model

//--- logic/swm_pkg.sv
package swm_pkg;
  // duty-cycle receive sequencing
  typedef enum logic [1:0] {DUTY_IDLE, DUTY_LISTEN, DUTY_WINDOW} swm_duty_t;
  // supply monitor schedule
  typedef enum logic {MON_WAIT, MON_MEASURE} swm_mon_t;
endpackage

//--- logic/swm_regs.svh
`ifndef SWM_REGS_SVH
`define SWM_REGS_SVH
// register offsets
`define SWM_ADDR_EXP 7'h14
`define SWM_ADDR_MANT_HI 7'h15
`define SWM_ADDR_MANT_LO 7'h16
`define SWM_ADDR_CNT_HI 7'h17
`define SWM_ADDR_CNT_LO 7'h18
`define SWM_ADDR_DUTY 7'h19
`define SWM_ADDR_THR 7'h1a
`define SWM_ADDR_LEVEL 7'h1b
// reset values
`define SWM_RST_EXP 5'h03
`define SWM_RST_MANT 16'h0000
`define SWM_RST_DUTY 8'h00
`define SWM_RST_THR 5'h14
// field padding of narrow registers
`define SWM_PAD_EXP 3'h0
`define SWM_PAD_LEVEL 3'h0
`define SWM_PAD_DUTY 8'h00
// timing
`define SWM_CLK_NS 40
`define SWM_MEAS_PERIOD_NS 1000000000
`define SWM_MEAS_ON_NS 250000
`define SWM_LOW_RUN 3'h4
`define SWM_SCALE_BASE 34'h4
`endif

//--- logic/swm_scaled_counter.sv
`include "swm_regs.svh"
module swm_scaled_counter (
  input wire logic clock,
  input wire logic nrst,
  swm_scaled_if.counter sc
);
  import swm_pkg::*;
  logic [33:0] pre_q, pre_d;
  logic [15:0] cnt_q, cnt_d;
  logic exp_q, exp_d;
  // one count per 4 * 2^exponent slow ticks, expiry at the limit
  always_comb
  begin
    pre_d = pre_q;
    cnt_d = cnt_q;
    exp_d = 1'b0;
    if (sc.start || !sc.run)
    begin
      pre_d = 34'h0;
      cnt_d = 16'h0;
    end
    else if (sc.tick)
    begin
      if (pre_q == (`SWM_SCALE_BASE << sc.exponent) - 34'h1)
      begin
        pre_d = 34'h0;
        if (sc.limit != 16'h0 && cnt_q == sc.limit - 16'h1)
        begin
          cnt_d = 16'h0;
          exp_d = 1'b1;
        end
        else
          cnt_d = cnt_q + 16'h1;
      end
      else
        pre_d = pre_q + 34'h1;
    end
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      pre_q <= 34'h0;
      cnt_q <= 16'h0;
      exp_q <= 1'b0;
    end
    else
    begin
      pre_q <= pre_d;
      cnt_q <= cnt_d;
      exp_q <= exp_d;
    end
  end
  assign sc.expire = exp_q;
  assign sc.count = cnt_q;
  reload_zero_a: assert property (@(posedge clock) disable iff (!nrst) exp_q |-> cnt_q == 16'h0)
    else $error("count not reloaded at expiry");
endmodule // swm_scaled_counter

//--- logic/swm_scaled_if.sv
interface swm_scaled_if;
  logic start;
  logic run;
  logic tick;
  logic [4:0] exponent;
  logic [15:0] limit;
  logic expire;
  logic [15:0] count;
  modport owner (output start, run, tick, exponent, limit, input expire, count);
  modport counter (input start, run, tick, exponent, limit, output expire, count);
endinterface

//--- logic/swm_supervisor.sv
`include "swm_regs.svh"
module swm_supervisor #(
  parameter int MEAS_INTERVAL = `SWM_MEAS_PERIOD_NS / `SWM_CLK_NS,
  parameter int MEAS_ON = (`SWM_MEAS_ON_NS + `SWM_CLK_NS - 1) / `SWM_CLK_NS
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic monitor_enable,
  input wire logic timer_enable,
  input wire logic slow_crystal_select,
  input wire logic duty_cycle_receive,
  input wire logic supply_irq_enable,
  input wire logic wakeup_irq_enable,
  input wire logic sleep_request,
  input wire logic irq_read,
  input wire logic rc_osc_pin,
  input wire logic slow_crystal_pin,
  input wire logic [4:0] supply_code,
  input wire logic rx_preamble_ok,
  input wire logic rx_sync_ok,
  input wire logic rx_search_fail,
  output logic irq_out_low,
  output logic xtal30_en,
  output logic host_clk_run,
  output logic rc_osc_en,
  output logic supply_monitor,
  output logic gpio0_crystal_mode,
  output logic wakeup_gpio,
  output logic rx_enable
);
  import swm_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [4:0] code_s1_q, code_s2_q;
  logic rc_s1_q, rc_s2_q, xt_s1_q, xt_s2_q, slow_prev_q;
  logic slow_sel, slow_tick;
  logic [4:0] exp_q, exp_d, thr_q, thr_d;
  logic [15:0] mant_q, mant_d;
  logic [7:0] duty_q, duty_d, rdata_q, rdata_d;
  logic sleep_q, sleep_d, sleep_run_q, sleep_run_d, timer_run;
  swm_duty_t dstate_q, dstate_d;
  logic rx_q, rx_d, win_start;
  logic wake_pend_q, wake_pend_d, batt_pend_q, batt_pend_d;
  logic irq_n_q, irq_n_d, xtal_q, xtal_d, rc_q, rc_d;
  logic gpio0_q, gpio0_d, wgpio_q, wgpio_d;
  logic mon_power, mon_event;
  logic [4:0] mon_level;
  swm_scaled_if period_if ();
  swm_scaled_if window_if ();

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for the analog code and the slow clock pins
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      code_s1_q <= 5'h0;
      code_s2_q <= 5'h0;
      rc_s1_q <= 1'b0;
      rc_s2_q <= 1'b0;
      xt_s1_q <= 1'b0;
      xt_s2_q <= 1'b0;
      slow_prev_q <= 1'b0;
    end
    else
    begin
      code_s1_q <= supply_code;
      code_s2_q <= code_s1_q;
      rc_s1_q <= rc_osc_pin;
      rc_s2_q <= rc_s1_q;
      xt_s1_q <= slow_crystal_pin;
      xt_s2_q <= xt_s1_q;
      slow_prev_q <= slow_sel;
    end
  end

  // slow source choice and rising-edge tick
  assign slow_sel = slow_crystal_select ? xt_s2_q : rc_s2_q;
  assign slow_tick = slow_sel & ~slow_prev_q;

  ////////////////////////////////////////////////////////////////////////
  // register writes and registered read data
  always_comb
  begin
    exp_d = exp_q;
    mant_d = mant_q;
    duty_d = duty_q;
    thr_d = thr_q;
    rdata_d = rdata_q;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `SWM_ADDR_EXP: exp_d = reg_wdata[4:0];
        `SWM_ADDR_MANT_HI: mant_d[15:8] = reg_wdata;
        `SWM_ADDR_MANT_LO: mant_d[7:0] = reg_wdata;
        `SWM_ADDR_DUTY: duty_d = reg_wdata;
        `SWM_ADDR_THR: thr_d = reg_wdata[4:0];
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        `SWM_ADDR_EXP: rdata_d = {`SWM_PAD_EXP, exp_q};
        `SWM_ADDR_MANT_HI: rdata_d = mant_q[15:8];
        `SWM_ADDR_MANT_LO: rdata_d = mant_q[7:0];
        `SWM_ADDR_CNT_HI: rdata_d = period_if.count[15:8];
        `SWM_ADDR_CNT_LO: rdata_d = period_if.count[7:0];
        `SWM_ADDR_DUTY: rdata_d = duty_q;
        `SWM_ADDR_THR: rdata_d = {`SWM_PAD_EXP, thr_q};
        `SWM_ADDR_LEVEL: rdata_d = {`SWM_PAD_LEVEL, mon_level};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      exp_q <= `SWM_RST_EXP;
      mant_q <= `SWM_RST_MANT;
      duty_q <= `SWM_RST_DUTY;
      thr_q <= `SWM_RST_THR;
      rdata_q <= 8'h00;
    end
    else
    begin
      exp_q <= exp_d;
      mant_q <= mant_d;
      duty_q <= duty_d;
      thr_q <= thr_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sleep tracking: the timer enable is captured as sleep begins
  always_comb
  begin
    sleep_d = sleep_request;
    sleep_run_d = sleep_run_q;
    if (sleep_request && !sleep_q)
      sleep_run_d = timer_enable;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      sleep_q <= 1'b0;
      sleep_run_q <= 1'b0;
    end
    else
    begin
      sleep_q <= sleep_d;
      sleep_run_q <= sleep_run_d;
    end
  end

  assign timer_run = sleep_q ? sleep_run_q : timer_enable;

  ////////////////////////////////////////////////////////////////////////
  // wake-up period and duty window counters share the exponent
  assign period_if.start = sleep_request & ~sleep_q;
  assign period_if.run = timer_run;
  assign period_if.tick = slow_tick;
  assign period_if.exponent = exp_q;
  assign period_if.limit = mant_q;
  assign window_if.start = win_start;
  assign window_if.run = (dstate_q == DUTY_WINDOW);
  assign window_if.tick = slow_tick;
  assign window_if.exponent = exp_q;
  assign window_if.limit = {`SWM_PAD_DUTY, duty_q};

  swm_scaled_counter u_period (
    .clock(clock),
    .nrst(nrst),
    .sc(period_if)
  );

  swm_scaled_counter u_window (
    .clock(clock),
    .nrst(nrst),
    .sc(window_if)
  );

  swm_supply_monitor #(
    .INTERVAL(MEAS_INTERVAL),
    .ON_TIME(MEAS_ON)
  ) u_monitor (
    .clock(clock),
    .nrst(nrst),
    .enable(monitor_enable),
    .code(code_s2_q),
    .threshold(thr_q),
    .power(mon_power),
    .level(mon_level),
    .low_event(mon_event)
  );

  ////////////////////////////////////////////////////////////////////////
  // duty-cycle receive: listen each period, extend on preamble plus sync
  always_comb
  begin
    dstate_d = dstate_q;
    rx_d = rx_q;
    win_start = 1'b0;
    if (!duty_cycle_receive)
    begin
      dstate_d = DUTY_IDLE;
      rx_d = 1'b0;
    end
    else
    begin
      unique case (dstate_q)
        DUTY_IDLE:
          if (period_if.expire)
          begin
            dstate_d = DUTY_LISTEN;
            rx_d = 1'b1;
          end
        DUTY_LISTEN:
          if (rx_preamble_ok && rx_sync_ok)
          begin
            dstate_d = DUTY_WINDOW;
            win_start = 1'b1;
          end
          else if (rx_search_fail)
          begin
            dstate_d = DUTY_IDLE;
            rx_d = 1'b0;
          end
        DUTY_WINDOW:
          if (window_if.expire)
          begin
            dstate_d = DUTY_IDLE;
            rx_d = 1'b0;
          end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      dstate_q <= DUTY_IDLE;
      rx_q <= 1'b0;
    end
    else
    begin
      dstate_q <= dstate_d;
      rx_q <= rx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending events, interrupt pin and clock requests; a set beats a read
  always_comb
  begin
    wake_pend_d = (wake_pend_q & ~irq_read) | (period_if.expire & wakeup_irq_enable);
    batt_pend_d = (batt_pend_q & ~irq_read) | (mon_event & supply_irq_enable);
    irq_n_d = ~(wake_pend_d | batt_pend_d);
    xtal_d = ~sleep_request | wake_pend_d | batt_pend_d | rx_d;
    rc_d = ~slow_crystal_select & (timer_run | (monitor_enable & sleep_request));
    gpio0_d = slow_crystal_select;
    wgpio_d = period_if.expire & ~wakeup_irq_enable;
  end

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      wake_pend_q <= 1'b0;
      batt_pend_q <= 1'b0;
      irq_n_q <= 1'b1;
      xtal_q <= 1'b1;
      rc_q <= 1'b0;
      gpio0_q <= 1'b0;
      wgpio_q <= 1'b0;
    end
    else
    begin
      wake_pend_q <= wake_pend_d;
      batt_pend_q <= batt_pend_d;
      irq_n_q <= irq_n_d;
      xtal_q <= xtal_d;
      rc_q <= rc_d;
      gpio0_q <= gpio0_d;
      wgpio_q <= wgpio_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_out_low = irq_n_q;
  assign xtal30_en = xtal_q;
  assign host_clk_run = xtal_q;
  assign rc_osc_en = rc_q;
  assign supply_monitor = mon_power;
  assign gpio0_crystal_mode = gpio0_q;
  assign wakeup_gpio = wgpio_q;
  assign rx_enable = rx_q;

  ////////////////////////////////////////////////////////////////////////
  // checks on the block's own outputs
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  logic [12:0] on_len_q;
  // helper: length of the current monitor power pulse
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
      on_len_q <= 13'h0;
    else
      on_len_q <= supply_monitor ? on_len_q + 13'h1 : 13'h0;
  end

  batt_irq_a: assert property (mon_event && supply_irq_enable |=> !irq_out_low)
    else $error("low supply did not raise interrupt");
  level_pad_a: assert property (reg_rd && reg_addr == `SWM_ADDR_LEVEL |=> reg_rdata[7:5] == 3'h0)
    else $error("level upper bits not zero");
  meas_len_a: assert property ($fell(supply_monitor) |-> on_len_q == 13'(MEAS_ON))
    else $error("monitor power pulse has wrong length");
  wake_irq_a: assert property (period_if.expire && wakeup_irq_enable |=> !irq_out_low && xtal30_en)
    else $error("expiry did not wake host");
  count_read_a: assert property (reg_rd && reg_addr == `SWM_ADDR_CNT_HI |=>
    reg_rdata == $past(period_if.count[15:8]))
    else $error("count high byte mismatch");
  gpio_route_a: assert property (period_if.expire && !wakeup_irq_enable |=> wakeup_gpio)
    else $error("expiry not routed to pin");
  crystal_mode_a: assert property (slow_crystal_select |=> gpio0_crystal_mode && !rc_osc_en)
    else $error("crystal select not applied");
  listen_off_a: assert property (dstate_q == DUTY_LISTEN && duty_cycle_receive && rx_search_fail
    && !(rx_preamble_ok && rx_sync_ok) |=> !rx_enable && dstate_q == DUTY_IDLE)
    else $error("receiver not released after failed search");
  window_hold_a: assert property (dstate_q == DUTY_LISTEN && duty_cycle_receive && rx_preamble_ok && rx_sync_ok
    |=> rx_enable && dstate_q == DUTY_WINDOW)
    else $error("window not extended");
  pend_clock_a: assert property (!irq_out_low |-> xtal30_en && host_clk_run)
    else $error("host clock stopped with interrupt pending");

  wake_c: cover property (period_if.expire && wakeup_irq_enable ##1 !irq_out_low);
  batt_c: cover property (mon_event && supply_irq_enable);
  window_c: cover property (dstate_q == DUTY_WINDOW && window_if.expire);
  read_c: cover property (reg_rd && reg_addr == `SWM_ADDR_LEVEL);
endmodule // swm_supervisor

//--- logic/swm_supply_monitor.sv
`include "swm_regs.svh"
module swm_supply_monitor #(
  parameter int INTERVAL = 25000000,
  parameter int ON_TIME = 6250
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic enable,
  input wire logic [4:0] code,
  input wire logic [4:0] threshold,
  output logic power,
  output logic [4:0] level,
  output logic low_event
);
  import swm_pkg::*;
  swm_mon_t state_q, state_d;
  logic [24:0] tmr_q, tmr_d;
  logic [2:0] run_q, run_d;
  logic power_q, power_d, event_q, event_d;
  logic [4:0] level_q, level_d;
  // one powered measurement per interval, low readings debounced
  always_comb
  begin
    state_d = state_q;
    tmr_d = tmr_q + 25'h1;
    run_d = run_q;
    power_d = power_q;
    event_d = 1'b0;
    level_d = level_q;
    if (!enable)
    begin
      state_d = MON_WAIT;
      tmr_d = 25'h0;
      run_d = 3'h0;
      power_d = 1'b0;
    end
    else
    begin
      unique case (state_q)
        MON_WAIT:
          if (tmr_q == 25'(INTERVAL - 1))
          begin
            state_d = MON_MEASURE;
            tmr_d = 25'h0;
            power_d = 1'b1;
          end
        MON_MEASURE:
          if (tmr_q == 25'(ON_TIME - 1))
          begin
            state_d = MON_WAIT;
            tmr_d = 25'h0;
            power_d = 1'b0;
            level_d = code;
            if (code < threshold)
            begin
              run_d = (run_q == `SWM_LOW_RUN) ? run_q : run_q + 3'h1;
              event_d = (run_q == `SWM_LOW_RUN - 3'h1);
            end
            else
              run_d = 3'h0;
          end
      endcase
    end
  end
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q <= MON_WAIT;
      tmr_q <= 25'h0;
      run_q <= 3'h0;
      power_q <= 1'b0;
      event_q <= 1'b0;
      level_q <= 5'h0;
    end
    else
    begin
      state_q <= state_d;
      tmr_q <= tmr_d;
      run_q <= run_d;
      power_q <= power_d;
      event_q <= event_d;
      level_q <= level_d;
    end
  end
  assign power = power_q;
  assign level = level_q;
  assign low_event = event_q;
  four_low_a: assert property (@(posedge clock) disable iff (!nrst) event_q |-> run_q == `SWM_LOW_RUN)
    else $error("low event without four low readings");
endmodule // swm_supply_monitor
